// *** design/isolator_regs.svh ***
// Timing counts and register map of the isolator command controller.
// Assumes a 25 MHz clock; millisecond figures stay in ms, CYC_PER_MS gives cycles per ms.
`ifndef ISOLATOR_REGS_SVH
`define ISOLATOR_REGS_SVH

`define CLK_HZ            25000000
`define CYC_PER_MS        (`CLK_HZ / 1000)
`define OPER_PULSE_MS     150
`define MIN_PULSE_MS      1000
`define PULSE_MS_DEF      16'd1000
`define PULSE_MS_MIN      16'd100
`define INTERMED_MS_DEF   16'd10000
`define INTERMED_MS_MIN   16'd20
`define MAX_OPER_MS_DEF   16'd10000
`define MAX_OPER_MS_MIN   16'd10
`define SELECT_MS_DEF     16'd5000
`define SELECT_MS_MIN     16'd1000
`define SETTING_MS_MAX    16'd60000
`define SELECT_MS_MAX     16'd20000

// Register offsets (byte addresses, one word each)
`define REG_CTRL          8'h00
`define REG_PULSE_MS      8'h04
`define REG_INTERMED_MS   8'h08
`define REG_MAX_OPER_MS   8'h0C
`define REG_SELECT_MS     8'h10
`define REG_STATUS        8'h14
`define REG_OP_COUNT      8'h18
`define REG_EVENT         8'h1C

// Control register fields
`define CTRL_CMD_OPEN     0
`define CTRL_CMD_CLOSE    1
`define CTRL_SELECT       2
`define CTRL_CNT_CLEAR    3
`define CTRL_MODEL_LO     4
`define CTRL_MODEL_HI     5

`endif

// *** design/isolator_pkg.sv ***
// Types shared by the isolator command controller.
// Timing and register constants live in isolator_regs.svh.
package isolator_pkg;
	typedef enum logic [1:0] {
		POS_INTERMEDIATE = 2'b00,
		POS_OFF          = 2'b01,
		POS_ON           = 2'b10,
		POS_BAD          = 2'b11
	} position_t;

	typedef enum logic [1:0] {
		MODEL_DIRECT_NORMAL   = 2'b00,
		MODEL_DIRECT_ENHANCED = 2'b01,
		MODEL_SBO_ENHANCED    = 2'b10
	} model_t;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_OPENING = 2'b01,
		ST_CLOSING = 2'b10
	} cmd_state_t;
endpackage

// *** design/isolator_command_control.sv ***
// Isolator switch command controller: request gating, timed command pulses,
// position filtering, operation pulse, counter and events.
// Assumes one 25 MHz clock; contacts and permission pins are asynchronous.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "isolator_regs.svh"

module isolator_command_control
	import isolator_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic             clk_en,
	input  wire logic             local_permit,
	input  wire logic             remote_permit,
	input  wire logic             open_permit,
	input  wire logic             close_permit,
	input  wire logic             operation_inhibit,
	input  wire logic             open_feedback,
	input  wire logic             closed_feedback,
	input  wire logic             panel_open_req,
	input  wire logic             panel_close_req,
	input  wire logic             switch_request_channel_valid,
	input  wire logic             switch_request_channel,
	input  wire logic [7:0]       addr,
	input  wire logic [31:0]      wdata,
	input  wire logic             wr,
	input  wire logic             rd,
	output logic      [31:0]      rdata,
	output logic                  open_pulse_out,
	output logic                  close_pulse_out,
	output logic                  operation_pulse,
	output logic                  opened,
	output logic                  closed,
	output logic      [1:0]       position_code,
	output logic                  event_valid,
	output logic                  invalid_position
);
	localparam int MS_CYC   = `CYC_PER_MS;
	localparam int MS_CW    = $clog2(MS_CYC);

	// Asynchronous pins pass two flops before use
	logic [1:0] sync1, sync2, sync3, sync4, sync5, sync6, sync7;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sync1 <= 2'h0; sync2 <= 2'h0; sync3 <= 2'h0; sync4 <= 2'h0;
			sync5 <= 2'h0; sync6 <= 2'h0; sync7 <= 2'h0;
		end else if (clk_en) begin
			sync1 <= {sync1[0], local_permit};
			sync2 <= {sync2[0], remote_permit};
			sync3 <= {sync3[0], open_permit};
			sync4 <= {sync4[0], close_permit};
			sync5 <= {sync5[0], operation_inhibit};
			sync6 <= {sync6[0], open_feedback};
			sync7 <= {sync7[0], closed_feedback};
		end
	end
	logic loc_ok, rem_ok, open_ok, close_ok, inhibit, fb_open, fb_closed;
	assign loc_ok    = sync1[1];
	assign rem_ok    = sync2[1];
	assign open_ok   = sync3[1];
	assign close_ok  = sync4[1];
	assign inhibit   = sync5[1];
	assign fb_open   = sync6[1];
	assign fb_closed = sync7[1];

	// Millisecond tick; all timers count it so accuracy is one ms
	logic [MS_CW-1:0] pre;
	logic             ms_tick;
	assign ms_tick = (pre == MS_CW'(MS_CYC - 1));
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			pre <= '0;
		else if (clk_en)
			pre <= ms_tick ? '0 : pre + 1'b1;
	end

	// Settings registers
	logic [15:0] pulse_ms, intermed_ms, max_oper_ms, select_ms;
	model_t      model;
	logic        sel_armed;
	logic [CNT_W-1:0] op_count;
	logic [1:0]  last_event;
	logic        err_flag;
	logic        sw_open, sw_close, sw_select, sw_clear;
	assign sw_open   = clk_en && wr && addr == `REG_CTRL && wdata[`CTRL_CMD_OPEN];
	assign sw_close  = clk_en && wr && addr == `REG_CTRL && wdata[`CTRL_CMD_CLOSE];
	assign sw_select = clk_en && wr && addr == `REG_CTRL && wdata[`CTRL_SELECT];
	assign sw_clear  = clk_en && wr && addr == `REG_CTRL && wdata[`CTRL_CNT_CLEAR];

	// Out-of-range ms settings are clamped rather than refused; a model code of 3 is ignored
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		clamp = (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pulse_ms    <= `PULSE_MS_DEF;
			intermed_ms <= `INTERMED_MS_DEF;
			max_oper_ms <= `MAX_OPER_MS_DEF;
			select_ms   <= `SELECT_MS_DEF;
			model       <= MODEL_DIRECT_NORMAL;
		end else if (clk_en && wr) begin
			unique case (addr)
				`REG_CTRL: begin
					if (wdata[`CTRL_MODEL_HI:`CTRL_MODEL_LO] != 2'b11)
						model <= model_t'(wdata[`CTRL_MODEL_HI:`CTRL_MODEL_LO]);
				end
				`REG_PULSE_MS:    pulse_ms    <= clamp(wdata[15:0], `PULSE_MS_MIN, `SETTING_MS_MAX);
				`REG_INTERMED_MS: intermed_ms <= clamp(wdata[15:0], `INTERMED_MS_MIN, `SETTING_MS_MAX);
				`REG_MAX_OPER_MS: max_oper_ms <= clamp(wdata[15:0], `MAX_OPER_MS_MIN, `SETTING_MS_MAX);
				`REG_SELECT_MS:   select_ms   <= clamp(wdata[15:0], `SELECT_MS_MIN, `SELECT_MS_MAX);
				default: ;
			endcase
		end
	end

	// Filtered position: a valid code is taken at once, an
	// intermediate or bad code only after the wait expires
	position_t raw_pos, pos;
	logic [15:0] intermed_cnt;
	assign raw_pos = position_t'({fb_closed, fb_open});
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pos          <= POS_INTERMEDIATE;
			intermed_cnt <= '0;
		end else if (clk_en) begin
			if (raw_pos == POS_OFF || raw_pos == POS_ON) begin
				pos          <= raw_pos;
				intermed_cnt <= '0;
			end else if (intermed_cnt >= intermed_ms) begin
				pos <= raw_pos;
			end else if (ms_tick) begin
				intermed_cnt <= intermed_cnt + 16'd1;
			end
		end
	end
	assign position_code = pos;
	assign opened        = (pos == POS_OFF);
	assign closed        = (pos == POS_ON);

	// Select-before-operate window
	logic [15:0] sel_cnt;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sel_armed <= 1'b0;
			sel_cnt   <= '0;
		end else if (clk_en) begin
			if (sw_select && rem_ok) begin
				sel_armed <= 1'b1;
				sel_cnt   <= '0;
			end else if (sw_open || sw_close || switch_request_channel_valid) begin
				sel_armed <= 1'b0;
			end else if (sel_armed && sel_cnt >= select_ms) begin
				sel_armed <= 1'b0;
			end else if (sel_armed && ms_tick) begin
				sel_cnt <= sel_cnt + 16'd1;
			end
		end
	end

	// Request gating
	logic rem_open, rem_close, want_open, want_close, rem_allowed;
	cmd_state_t state;
	assign rem_allowed = rem_ok && (model != MODEL_SBO_ENHANCED || sel_armed);
	assign rem_open    = (sw_open || (switch_request_channel_valid && !switch_request_channel)) && rem_allowed;
	assign rem_close   = (sw_close || (switch_request_channel_valid && switch_request_channel)) && rem_allowed;
	assign want_open   = ((panel_open_req && loc_ok) || rem_open) && open_ok && !inhibit;
	assign want_close  = ((panel_close_req && loc_ok) || rem_close) && close_ok && !inhibit;

	// Command pulse sequencer
	logic [15:0] pulse_cnt, oper_cnt;
	logic        confirmed;
	assign confirmed = (state == ST_OPENING && pos == POS_OFF) || (state == ST_CLOSING && pos == POS_ON);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state     <= ST_IDLE;
			pulse_cnt <= '0;
		end else if (clk_en) begin
			unique case (state)
				ST_IDLE: begin
					pulse_cnt <= '0;
					if (want_open && !want_close)
						state <= ST_OPENING;
					else if (want_close && !want_open)
						state <= ST_CLOSING;
				end
				ST_OPENING, ST_CLOSING: begin
					if (inhibit || pulse_cnt >= pulse_ms ||
					    (confirmed && pulse_cnt >= 16'(`MIN_PULSE_MS)))
						state <= ST_IDLE;
					else if (ms_tick)
						pulse_cnt <= pulse_cnt + 16'd1;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
	assign open_pulse_out  = (state == ST_OPENING) && !inhibit;
	assign close_pulse_out = (state == ST_CLOSING) && !inhibit;

	// Enhanced models: position must change within the operating time
	logic watching;
	position_t start_pos;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			watching  <= 1'b0;
			oper_cnt  <= '0;
			err_flag  <= 1'b0;
			start_pos <= POS_INTERMEDIATE;
		end else if (clk_en) begin
			if (state == ST_IDLE && (want_open ^ want_close) && model != MODEL_DIRECT_NORMAL) begin
				watching  <= 1'b1;
				oper_cnt  <= '0;
				start_pos <= pos;
			end else if (watching && pos != start_pos) begin
				watching <= 1'b0;
			end else if (watching && oper_cnt >= max_oper_ms) begin
				watching <= 1'b0;
				err_flag <= 1'b1;
			end else if (watching && ms_tick) begin
				oper_cnt <= oper_cnt + 16'd1;
			end
			if (rd && addr == `REG_STATUS && !(watching && oper_cnt >= max_oper_ms))
				err_flag <= 1'b0;
		end
	end
	assign invalid_position = err_flag;

	// Operation pulse on an off/on transition, counted
	position_t prev_pos;
	logic [15:0] op_ms;
	logic        op_start;
	assign op_start = (pos != prev_pos) && (pos == POS_OFF || pos == POS_ON) &&
	                  (prev_pos == POS_OFF || prev_pos == POS_ON);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			prev_pos        <= POS_INTERMEDIATE;
			operation_pulse <= 1'b0;
			op_ms           <= '0;
		end else if (clk_en) begin
			if (pos == POS_OFF || pos == POS_ON)
				prev_pos <= pos;
			if (op_start) begin
				operation_pulse <= 1'b1;
				op_ms           <= '0;
			end else if (operation_pulse && op_ms >= 16'(`OPER_PULSE_MS)) begin
				operation_pulse <= 1'b0;
			end else if (operation_pulse && ms_tick) begin
				op_ms <= op_ms + 16'd1;
			end
		end
	end

	// Counter: a new operation in the clear cycle still counts
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			op_count <= '0;
		else if (clk_en) begin
			if (op_start)
				op_count <= sw_clear ? CNT_W'(1) : op_count + 1'b1;
			else if (sw_clear)
				op_count <= '0;
		end
	end

	// Events on every change of the reported position code
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			event_valid <= 1'b0;
			last_event  <= POS_INTERMEDIATE;
		end else if (clk_en) begin
			event_valid <= (pos != last_event);
			last_event  <= pos;
		end
	end

	// Read port, data valid the cycle after the strobe
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			rdata <= '0;
		else if (clk_en) begin
			if (rd) begin
				unique case (addr)
					`REG_CTRL:        rdata <= {26'h0, model, 4'h0};
					`REG_PULSE_MS:    rdata <= {16'h0, pulse_ms};
					`REG_INTERMED_MS: rdata <= {16'h0, intermed_ms};
					`REG_MAX_OPER_MS: rdata <= {16'h0, max_oper_ms};
					`REG_SELECT_MS:   rdata <= {16'h0, select_ms};
					`REG_STATUS:      rdata <= {24'h0, err_flag, sel_armed, state, operation_pulse, 1'b0, pos};
					`REG_OP_COUNT:    rdata <= 32'(op_count);
					`REG_EVENT:       rdata <= {30'h0, last_event};
					default:          rdata <= '0;
				endcase
			end else
				rdata <= '0;
		end
	end
endmodule

// *** verification/isolator_properties.sv ***
// Concurrent checks on the ports of the isolator command controller.
// Assumes one clock domain; reset is asynchronous and active low.
`timescale 1ns/1ps
module isolator_properties
	import isolator_pkg::*;
(
	input wire logic       clock,
	input wire logic       rstn,
	input wire logic       operation_inhibit,
	input wire logic       open_feedback,
	input wire logic       closed_feedback,
	input wire logic       open_pulse_out,
	input wire logic       close_pulse_out,
	input wire logic       operation_pulse,
	input wire logic       opened,
	input wire logic       closed,
	input wire logic [1:0] position_code,
	input wire logic       event_valid
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	// Command outputs never overlap
	cmd_exclusive_a: assert property (!(open_pulse_out && close_pulse_out))
		else $error("open and close commands active together");
	// Two sync stages plus gating: three cycles of inhibit must clear both
	inhibit_block_a: assert property (operation_inhibit [*3] |-> !open_pulse_out && !close_pulse_out)
		else $error("command active under inhibit");
	off_code_a: assert property ((open_feedback && !closed_feedback) [*8] |-> position_code == POS_OFF)
		else $error("open contact not coded as off");
	on_code_a: assert property ((closed_feedback && !open_feedback) [*8] |-> position_code == POS_ON)
		else $error("closed contact not coded as on");
	// Flag rises three edges after the contacts settle: two sync stages and the filter
	closed_flag_a: assert property ($rose(closed) |-> $past(closed_feedback, 3) && !$past(open_feedback, 3))
		else $error("closed flag without closed contact");
	opened_flag_a: assert property ($rose(opened) |-> $past(open_feedback, 3) && !$past(closed_feedback, 3))
		else $error("opened flag without open contact");
	code_event_a: assert property (position_code != $past(position_code) |-> ##[0:1] event_valid)
		else $error("position change without event");
	oper_kind_a: assert property ($rose(operation_pulse) |-> position_code inside {POS_OFF, POS_ON})
		else $error("operation pulse outside off or on");
	oper_hold_a: assert property ($rose(operation_pulse) |=> operation_pulse [*8])
		else $error("operation pulse cut short");
	open_hold_a: assert property ($rose(open_pulse_out) |=> open_pulse_out [*8])
		else $error("open pulse cut short");
	close_hold_a: assert property ($rose(close_pulse_out) |=> close_pulse_out [*8])
		else $error("close pulse cut short");

	open_seen_c: cover property ($rose(open_pulse_out));
	close_seen_c: cover property ($rose(close_pulse_out));
	oper_seen_c: cover property ($rose(operation_pulse));
endmodule

bind isolator_command_control isolator_properties isolator_properties_i (.clock, .rstn, .operation_inhibit,
	.open_feedback, .closed_feedback, .open_pulse_out, .close_pulse_out, .operation_pulse, .opened, .closed,
	.position_code, .event_valid);

// *** verification/switchgear_model.sv ***
// Contact model of the isolating switch behind the command outputs.
// Assumes the bench changes set_pos only right after a rising edge.
`timescale 1ns/1ps
module switchgear_model #(
	parameter int TRAVEL = 40
) (
	input  wire logic       clock,
	input  wire logic       open_cmd,
	input  wire logic       close_cmd,
	input  wire logic       set_en,
	input  wire logic [1:0] set_pos,
	output logic            open_feedback = 1'h0,
	output logic            closed_feedback = 1'h0
);
	int travel_cnt = 0;

	// Blades leave both contacts while travelling, land after TRAVEL cycles
	always @(posedge clock) begin
		if (set_en) begin
			{closed_feedback, open_feedback} <= set_pos;
			travel_cnt <= 0;
		end else if (open_cmd || close_cmd) begin
			travel_cnt <= travel_cnt + 1;
			if (travel_cnt == 1)
				{closed_feedback, open_feedback} <= 2'h0;
			if (travel_cnt == TRAVEL)
				{closed_feedback, open_feedback} <= {close_cmd, open_cmd};
		end else
			travel_cnt <= 0;
	end
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the isolator command controller.
// Assumes a 25 MHz clock; the ms timers are far too long to expire in this run.
`timescale 1ns/1ps
`include "isolator_regs.svh"
module tb_top
	import isolator_pkg::*;
;
	logic        clock = 1'h0;
	logic        rstn, clk_en, wr, rd, set_en, switch_request_channel, open_feedback, closed_feedback;
	logic        open_pulse_out, close_pulse_out, operation_pulse, opened, closed, event_valid, invalid_position;
	logic        rd_seen = 1'h0;
	logic [4:0]  pins;
	logic [2:0]  req_v;
	logic [1:0]  set_pos, position_code;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, pw;
	logic [31:0] exp_q[$];
	logic [7:0]  def_a[6] = '{`REG_PULSE_MS, `REG_INTERMED_MS, `REG_MAX_OPER_MS, `REG_SELECT_MS, `REG_OP_COUNT, 8'h20};
	logic [31:0] def_v[6] = '{32'h3E8, 32'h2710, 32'h2710, 32'h1388, 32'h0, 32'h0};
	logic [4:0]  gate_p[5] = '{5'h0E, 5'h0B, 5'h07, 5'h1F, 5'h0D};
	logic [2:0]  gate_r[5] = '{3'h1, 3'h1, 3'h2, 3'h1, 3'h4};
	int          fails = 0;
	int          check_count = 0;
	int          cyc = 0;

	initial forever #20 clock = ~clock;

	// Pins: inhibit, close permit, open permit, remote, local
	isolator_command_control isolator_command_control_i (.clock, .rstn, .clk_en, .local_permit(pins[0]),
		.remote_permit(pins[1]), .open_permit(pins[2]), .close_permit(pins[3]), .operation_inhibit(pins[4]),
		.open_feedback, .closed_feedback, .panel_open_req(req_v[0]), .panel_close_req(req_v[1]),
		.switch_request_channel_valid(req_v[2]), .switch_request_channel, .addr, .wdata, .wr, .rd, .rdata,
		.open_pulse_out, .close_pulse_out, .operation_pulse, .opened, .closed, .position_code, .event_valid,
		.invalid_position);
	switchgear_model switchgear_model_i (.clock, .open_cmd(open_pulse_out), .close_cmd(close_pulse_out),
		.set_en, .set_pos, .open_feedback, .closed_feedback);

	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic close_out;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr_reg(logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		wr    <= 1'h1;
		addr  <= a;
		wdata <= d;
		@(posedge clock);
		wr    <= 1'h0;
	endtask
	// Expected answer is noted now, compared by the monitor
	task automatic rd_reg(logic [7:0] a, logic [31:0] e);
		@(posedge clock);
		rd   <= 1'h1;
		addr <= a;
		exp_q.push_back(e);
		@(posedge clock);
		rd   <= 1'h0;
		@(posedge clock);
	endtask
	task automatic req(logic [2:0] v);
		@(posedge clock);
		req_v <= v;
		@(posedge clock);
		req_v <= 3'h0;
		tick(6);
	endtask
	task automatic place(logic [1:0] p);
		@(posedge clock);
		set_en  <= 1'h1;
		set_pos <= p;
		@(posedge clock);
		set_en  <= 1'h0;
		tick(10);
	endtask
	// A pulse cannot run out within the run, so reset ends it
	task automatic do_reset;
		@(posedge clock);
		rstn <= 1'h0;
		repeat (2) @(posedge clock);
		rstn <= 1'h1;
		tick(4);
	endtask

	// Read data stand one cycle after the strobe; hang guard too
	always @(posedge clock) begin
		if (rd_seen === 1'h1)
			chk("rdata", exp_q.pop_front(), rdata);
		rd_seen <= rd;
		cyc++;
		if (cyc == 20000) begin
			fails++;
			close_out;
		end
	end

	initial begin
		rstn = 1'h0;
		clk_en = 1'h1;
		pins = 5'h0;
		req_v = 3'h0;
		switch_request_channel = 1'h1;
		addr = 8'h0;
		wdata = 32'h0;
		wr = 1'h0;
		rd = 1'h0;
		set_en = 1'h1;
		set_pos = 2'h0;
		pw = 32'd100 + $urandom(78890) % 32'd59901;
		repeat (16) @(posedge clock);
		rstn <= 1'h1;
		tick(4);
		foreach (def_a[i]) rd_reg(def_a[i], def_v[i]);
		wr_reg(`REG_PULSE_MS, pw);
		rd_reg(`REG_PULSE_MS, pw);
		place(POS_OFF);
		chk("code", POS_OFF, position_code);
		chk("opened", 1'h1, opened);
		place(POS_ON);
		chk("code", POS_ON, position_code);
		chk("closed", 1'h1, closed);
		chk("oper", 1'h1, operation_pulse);
		rd_reg(`REG_OP_COUNT, 32'h1);
		rd_reg(`REG_STATUS, 32'hA);
		rd_reg(`REG_EVENT, 32'h2);
		wr_reg(`REG_CTRL, 32'h8);
		rd_reg(`REG_OP_COUNT, 32'h0);
		place(POS_INTERMEDIATE);
		chk("code", POS_ON, position_code);
		place(POS_BAD);
		chk("code", POS_ON, position_code);
		// Each entry lacks one condition; nothing may start
		foreach (gate_p[i]) begin
			@(posedge clock) pins <= gate_p[i];
			// Two sync stages must settle before the request
			tick(2);
			req(gate_r[i]);
			chk("cmds", 2'h0, {close_pulse_out, open_pulse_out});
		end
		for (int c = 0; c < 2; c++) begin
			@(posedge clock);
			pins <= 5'h0E;
			switch_request_channel <= c[0];
			tick(2);
			req(3'h4);
			chk("cmds", c ? 2'h2 : 2'h1, {close_pulse_out, open_pulse_out});
			if (c == 0) begin
				@(posedge clock) switch_request_channel <= 1'h1;
				req(3'h4);
				chk("close_cmd", 1'h0, close_pulse_out);
				@(posedge clock) pins <= 5'h1E;
				tick(4);
				chk("open_cmd", 1'h0, open_pulse_out);
			end
			do_reset;
		end
		@(posedge clock) pins <= 5'h0E;
		tick(4);
		wr_reg(`REG_CTRL, 32'h1);
		tick(4);
		chk("open_cmd", 1'h1, open_pulse_out);
		do_reset;
		// Select-then-operate: an unselected operate is dropped
		wr_reg(`REG_CTRL, 32'h20);
		wr_reg(`REG_CTRL, 32'h21);
		tick(4);
		chk("open_cmd", 1'h0, open_pulse_out);
		wr_reg(`REG_CTRL, 32'h24);
		wr_reg(`REG_CTRL, 32'h21);
		tick(4);
		chk("open_cmd", 1'h1, open_pulse_out);
		chk("invalid", 1'h0, invalid_position);
		close_out;
	end
endmodule
